// >>> rtl/split_reload_timer_pkg.sv
package split_reload_timer_pkg;
  localparam logic [7:0] TIMER_CONTROL_ADDR = 8'hc8;
  localparam logic [7:0] RELOAD_LOW_ADDR = 8'hca;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hcc;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hcd;
  localparam int HIGH_FLAG_BIT = 7;
  localparam int LOW_FLAG_BIT = 6;
  localparam int LOW_IRQ_EN_BIT = 5;
  localparam int SPLIT_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int ALT_CLK_BIT = 0;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hed;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
endpackage

// >>> rtl/split_reload_timer.sv
`timescale 1ns/1ps
module split_reload_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrWrite,
  output logic [7:0] sfrRdata,
  input wire logic bitWrite,
  input wire logic [2:0] bitSel,
  input wire logic bitValue,
  input wire logic timerIrqEnable,
  input wire logic lowByteSysclkSelect,
  input wire logic highByteSysclkSelect,
  input wire logic extClock,
  output logic irqRequest,
  output logic [7:0] timerControl,
  output logic [7:0] countLowByte,
  output logic [7:0] countHighByte
);
  logic [7:0] control_q;
  logic [7:0] reloadLow_q;
  logic [7:0] reloadHigh_q;
  logic [7:0] countLow_q;
  logic [7:0] countHigh_q;
  logic [3:0] div12_q;
  logic [2:0] extSync_q;
  logic [2:0] extDiv_q;
  logic extDivOld_q;
  logic divTick;
  logic extTick;
  logic altTick;
  logic lowTick;
  logic highTick;
  logic splitMode;
  logic runOn;
  logic lowStep;
  logic highStep;
  logic lowWrap;
  logic highWrap;
  logic [7:0] ctrlWrEff;
  logic ctrlWr;
  logic ctrlBitWr;
  logic [7:0] bitMask;
  logic [7:0] ctrlNext;
  logic [7:0] ctrlUpdate;
  logic [7:0] controlView;
  logic wrReloadLow;
  logic wrReloadHigh;
  logic wrCountLow;
  logic wrCountHigh;

  assign splitMode = control_q[split_reload_timer_pkg::SPLIT_BIT];
  assign runOn = control_q[split_reload_timer_pkg::RUN_BIT];

  assign divTick = (div12_q == 4'(split_reload_timer_pkg::SYS_DIV - 1));
  assign altTick = control_q[split_reload_timer_pkg::ALT_CLK_BIT] ?
    extTick : divTick;
  assign lowTick = lowByteSysclkSelect ? 1'b1 : altTick;
  assign highTick = splitMode ?
    (highByteSysclkSelect ? 1'b1 : altTick) : lowTick;

  assign lowStep = splitMode ? lowTick : (lowTick & runOn);
  assign highStep = splitMode ? (highTick & runOn) :
    (lowStep & (countLow_q == 8'hff));
  assign lowWrap = lowStep & (countLow_q == 8'hff);
  assign highWrap = highStep & (countHigh_q == 8'hff);

  assign wrReloadLow = sfrWrite &
    (sfrAddr == split_reload_timer_pkg::RELOAD_LOW_ADDR);
  assign wrReloadHigh = sfrWrite &
    (sfrAddr == split_reload_timer_pkg::RELOAD_HIGH_ADDR);
  assign wrCountLow = sfrWrite &
    (sfrAddr == split_reload_timer_pkg::COUNT_LOW_ADDR);
  assign wrCountHigh = sfrWrite &
    (sfrAddr == split_reload_timer_pkg::COUNT_HIGH_ADDR);
  assign ctrlWr = sfrWrite &
    (sfrAddr == split_reload_timer_pkg::TIMER_CONTROL_ADDR);
  assign ctrlBitWr = bitWrite & ~ctrlWr;
  assign bitMask = 8'h01 << bitSel;

  assign ctrlWrEff = ctrlWr ? sfrWdata :
    (bitValue ? (control_q | bitMask) : (control_q & ~bitMask));
  assign ctrlUpdate = (ctrlWr | ctrlBitWr) ?
    (ctrlWrEff & split_reload_timer_pkg::CONTROL_WRITE_MASK) : control_q;
  // flags set by wraps, set wins over clear
  assign ctrlNext = ctrlUpdate |
    {highWrap, lowWrap, 6'h00};
  assign controlView = control_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      extSync_q <= 3'h0;
      extDiv_q <= 3'h0;
      extDivOld_q <= 1'b0;
    end else begin
      extSync_q <= {extSync_q[1:0], extClock};
      if (extSync_q[1] & ~extSync_q[2]) begin
        extDiv_q <= extDiv_q + 3'h1;
      end
      extDivOld_q <= extDiv_q[2];
    end
  end
  assign extTick = extDiv_q[2] & ~extDivOld_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div12_q <= 4'h0;
    end else if (divTick) begin
      div12_q <= 4'h0;
    end else begin
      div12_q <= div12_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_q <= split_reload_timer_pkg::REG_RESET;
    end else begin
      control_q <= ctrlNext;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reloadLow_q <= split_reload_timer_pkg::REG_RESET;
      reloadHigh_q <= split_reload_timer_pkg::REG_RESET;
    end else begin
      if (wrReloadLow) begin
        reloadLow_q <= sfrWdata;
      end
      if (wrReloadHigh) begin
        reloadHigh_q <= sfrWdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      countLow_q <= split_reload_timer_pkg::REG_RESET;
      countHigh_q <= split_reload_timer_pkg::REG_RESET;
    end else begin
      if (wrCountLow) begin
        countLow_q <= sfrWdata;
      end else if (lowWrap & (splitMode | highWrap)) begin
        countLow_q <= reloadLow_q;
      end else if (lowStep) begin
        countLow_q <= countLow_q + 8'h01;
      end
      if (wrCountHigh) begin
        countHigh_q <= sfrWdata;
      end else if (highWrap) begin
        countHigh_q <= reloadHigh_q;
      end else if (highStep) begin
        countHigh_q <= countHigh_q + 8'h01;
      end
    end
  end

  assign irqRequest = timerIrqEnable &
    (control_q[split_reload_timer_pkg::HIGH_FLAG_BIT] |
    (control_q[split_reload_timer_pkg::LOW_FLAG_BIT] &
    control_q[split_reload_timer_pkg::LOW_IRQ_EN_BIT]));

  always_comb begin
    unique case (sfrAddr)
      split_reload_timer_pkg::TIMER_CONTROL_ADDR: sfrRdata = controlView;
      split_reload_timer_pkg::RELOAD_LOW_ADDR: sfrRdata = reloadLow_q;
      split_reload_timer_pkg::RELOAD_HIGH_ADDR: sfrRdata = reloadHigh_q;
      split_reload_timer_pkg::COUNT_LOW_ADDR: sfrRdata = countLow_q;
      split_reload_timer_pkg::COUNT_HIGH_ADDR: sfrRdata = countHigh_q;
      default: sfrRdata = 8'h00;
    endcase
  end

  assign timerControl = control_q;
  assign countLowByte = countLow_q;
  assign countHighByte = countHigh_q;
endmodule

// >>> test/split_reload_timer_chk.sv
`timescale 1ns/1ps
module split_reload_timer_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrWrite,
  input wire logic bitWrite,
  input wire logic timerIrqEnable,
  input wire logic irqRequest,
  input wire logic [7:0] timerControl,
  input wire logic [7:0] countLowByte,
  input wire logic [7:0] countHighByte
);
  wire logic [7:0] tc = timerControl;
  wire logic [7:0] lo = countLowByte;
  wire logic [7:0] hi = countHighByte;
  wire logic quiet = !sfrWrite && !bitWrite;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_wrap16;
    !tc[3] && quiet && {hi, lo} == 16'hffff ##1 {hi, lo} != 16'hffff;
  endsequence
  sequence s_lowWrap; tc[3] && quiet && lo == 8'hff ##1 lo != 8'hff; endsequence
  sequence s_hiWrap; tc[3] && quiet && hi == 8'hff ##1 hi != 8'hff; endsequence
  property p_irq; irqRequest == (timerIrqEnable && (tc[7] || tc[6] && tc[5]));
  endproperty
  property p_unused; tc[4] == 1'b0 && tc[1] == 1'b0; endproperty
  property p_flag;
    $fell(tc[7]) || $fell(tc[6]) |-> $past(sfrWrite) || $past(bitWrite);
  endproperty
  property p_wrap16; s_wrap16 |-> tc[7] && tc[6]; endproperty
  property p_lowWrap; s_lowWrap |-> tc[6]; endproperty
  property p_hiWrap; s_hiWrap |-> tc[7]; endproperty
  property p_hold; !tc[3] && !tc[2] && quiet |=> $stable({hi, lo}); endproperty
  property p_wrLow; sfrWrite && sfrAddr == 8'hcc |=> lo == $past(sfrWdata);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  a_unused: assert property (p_unused) else $error("unused bits");
  a_flag: assert property (p_flag) else $error("flag cleared");
  a_wrap16: assert property (p_wrap16) else $error("wrap16");
  a_lowWrap: assert property (p_lowWrap) else $error("low wrap");
  a_hiWrap: assert property (p_hiWrap) else $error("high wrap");
  a_hold: assert property (p_hold) else $error("stopped moved");
  a_wrLow: assert property (p_wrLow) else $error("count write");
endmodule
bind split_reload_timer split_reload_timer_chk i_chk (.sys_clk(sys_clk),
  .rst(rst), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWrite(sfrWrite),
  .bitWrite(bitWrite), .timerIrqEnable(timerIrqEnable),
  .irqRequest(irqRequest), .timerControl(timerControl),
  .countLowByte(countLowByte), .countHighByte(countHighByte));

// >>> test/split_reload_timer_bench.sv
`timescale 1ns/1ps
module split_reload_timer_bench;
  logic sys_clk = 1'b0, rst = 1'b1, sfrWrite = 1'b0, bitWrite = 1'b0;
  logic bitValue = 1'b0, timerIrqEnable = 1'b1, extClock = 1'b0;
  logic lowByteSysclkSelect = 1'b1, highByteSysclkSelect = 1'b1;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, r = 8'h00;
  logic [2:0] bitSel = 3'h0;
  logic [7:0] sfrRdata, timerControl, countLowByte, countHighByte;
  logic irqRequest;
  logic [15:0] e;
  int fails = 0, comparisons = 0, seed = 81;
  split_reload_timer i_split_reload_timer (.sys_clk(sys_clk), .rst(rst),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWrite(sfrWrite),
    .sfrRdata(sfrRdata), .bitWrite(bitWrite), .bitSel(bitSel),
    .bitValue(bitValue), .timerIrqEnable(timerIrqEnable),
    .lowByteSysclkSelect(lowByteSysclkSelect),
    .highByteSysclkSelect(highByteSysclkSelect), .extClock(extClock),
    .irqRequest(irqRequest), .timerControl(timerControl),
    .countLowByte(countLowByte), .countHighByte(countHighByte));
  initial forever #10 sys_clk = !sys_clk;
  function automatic logic [15:0] adv(input logic [15:0] c, rl, input int n);
    repeat (n) c = (c == 16'hffff) ? rl : c + 16'h0001;
    return c;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic b, input logic [7:0] a, d);
    cyc(1);
    sfrAddr = a;
    bitSel = a[2:0];
    sfrWdata = d;
    bitValue = d[0];
    sfrWrite = !b;
    bitWrite = b;
    cyc(1);
    sfrWrite = 1'b0;
    bitWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    cyc(1);
    sfrAddr = a;
    #1 chk(sfrRdata, exp);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    rst = 1'b0;
    for (int a = 8'hc8; a < 8'hce; a++) rd(8'(a), 8'h00);
    r = 8'($random(seed)) & 8'h7f;
    put(1'b0, 8'hca, r);
    put(1'b0, 8'hcb, ~r);
    put(1'b0, 8'hc8, 8'h32);
    put(1'b0, 8'hc9, 8'h55);
    rd(8'hca, r);
    rd(8'hcb, ~r);
    rd(8'hc8, 8'h20);
    rd(8'hc9, 8'h00);
    $display("registers done");
    put(1'b0, 8'hcc, 8'hfe);
    put(1'b0, 8'hcd, 8'hff);
    put(1'b0, 8'hc8, 8'h24);
    cyc(5);
    e = adv(16'hfffe, {~r, r}, 5);
    chk(countLowByte, e[7:0]);
    chk(countHighByte, e[15:8]);
    rd(8'hc8, 8'he4);
    chk({7'h00, irqRequest}, 8'h01);
    put(1'b0, 8'hc8, 8'h00);
    chk({7'h00, irqRequest}, 8'h00);
    lowByteSysclkSelect = 1'b0;
    put(1'b0, 8'hcc, 8'h00);
    put(1'b0, 8'hcd, 8'h00);
    put(1'b0, 8'hc8, 8'h04);
    cyc(24);
    chk(countLowByte, 8'h02);
    put(1'b0, 8'hc8, 8'h05);
    put(1'b0, 8'hcc, 8'h00);
    repeat (32) begin
      cyc(2);
      extClock = !extClock;
    end
    cyc(6);
    chk(countLowByte, 8'h02);
    $display("clock sources done");
    lowByteSysclkSelect = 1'b1;
    highByteSysclkSelect = 1'b0;
    put(1'b0, 8'hc8, 8'h28);
    put(1'b0, 8'hcd, 8'h07);
    put(1'b0, 8'hcc, 8'hfe);
    cyc(3);
    e = adv(16'hfffe, {8'hff, r}, 3);
    chk(countLowByte, e[7:0]);
    chk(countHighByte, 8'h07);
    rd(8'hc8, 8'h68);
    chk({7'h00, irqRequest}, 8'h01);
    put(1'b1, 8'h06, 8'h00);
    chk({7'h00, irqRequest}, 8'h00);
    put(1'b0, 8'hcd, 8'hff);
    put(1'b1, 8'h02, 8'h01);
    cyc(24);
    e = adv(16'hffff, {8'hff, ~r}, 2);
    chk(countHighByte, e[7:0]);
    rd(8'hc8, 8'hac);
    chk({7'h00, irqRequest}, 8'h01);
    $display("split mode done");
    end_of_test;
  end
endmodule
